// ===== design/hbcsr_pkg.sv
// Constants and types for the host bridge configuration register slice
package hbcsr_pkg;

    // ------------------------------------------------------------------
    // Configuration offsets (byte addresses of aligned dwords, except the scrub word at 52h inside the 50h dword)
    // ------------------------------------------------------------------
    localparam logic [7:0] HBCSR_OFS_SUBSYS   = 8'h2c;
    localparam logic [7:0] HBCSR_OFS_CAPABILITY_LIST_POINTER   = 8'h34;
    localparam logic [7:0] HBCSR_OFS_CFG0     = 8'h50;
    localparam logic [7:0] HBCSR_OFS_SCRUB    = 8'h52;
    localparam logic [7:0] HBCSR_DWORD_MASK   = 8'hfc;

    // ------------------------------------------------------------------
    // Reset and fixed values
    // ------------------------------------------------------------------
    localparam logic [15:0] HBCSR_SUBSYS_RST   = 16'h0000;
    localparam logic [7:0]  HBCSR_CAP_OFFSET   = 8'h40;
    localparam logic [4:0]  HBCSR_CFG0_HI_RSV  = 5'h01;
    localparam logic        HBCSR_IN_ORDER_QUEUE_DEPTH_BIT_RST     = 1'h1;
    localparam logic [15:0] HBCSR_SCRUB_RST    = 16'h0000;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int HBCSR_CFG0_IN_ORDER_QUEUE_DEPTH_BIT_BIT  = 2;
    localparam int HBCSR_SCRB_WFLAG_BIT = 9;
    localparam int HBCSR_SCRB_RFLAG_BIT = 8;
    localparam int HBCSR_SCRB_CNT_LO    = 5;
    localparam int HBCSR_SCRB_MODE_LO   = 0;

    // ------------------------------------------------------------------
    // Scrub mode codes
    // ------------------------------------------------------------------
    localparam logic [1:0] HBCSR_SCRUB_OFF = 2'h0;
    localparam logic [1:0] HBCSR_SCRUB_ON  = 2'h2;

    // ------------------------------------------------------------------
    // In-order queue depths
    // ------------------------------------------------------------------
    localparam logic [3:0] HBCSR_IOQ_SINGLE = 4'h1;
    localparam logic [3:0] HBCSR_IOQ_MAX    = 4'hc;

    typedef struct packed {
        logic [15:0] board_vendor_field;
        logic [15:0] board_product_field;
        logic        subsys_locked;
        logic        in_order_queue_depth_bit;
        logic        proc_reset_n_seen;
        logic [3:0]  in_order_queue;
        logic [1:0]  scrub_mode;
        logic [1:0]  scrub_count;
        logic        write_throttle_flag;
        logic        read_throttle_flag;
        logic [31:0] rdata;
    } hbcsr_state_s;

endpackage : hbcsr_pkg

// ===== design/hbcsr_regs.sv
// Configuration register slice: subsystem identity, pointer, strap, scrub

// Overview of operation
// - Vendor and product identity form one 32-bit register that locks on any first write to its dword.
// - The capability pointer is read-only and always returns 40h.
// - Bit 2 of the configuration register captures the strap line when processor reset releases.
// - A strap sampled asserted reads 0 and limits the in-order queue to one entry.
// - A strap sampled deasserted reads 1 and sets the in-order queue to twelve entries.
// - The configuration register resets to 0Ch, bits 7:3 reading 01h and bits 1:0 zero.
// - Hardware sets bit 9 on a throttled write; software clears it by writing zero.
// - Hardware sets bit 8 on a throttled read; software clears it by writing zero.
// - Bits 6:5 count completed scrub passes from zero, wrapping from 11 to 00.
// - Scrub mode 00 turns the scrubber off, 10 turns it on, 01 and 11 are reserved.
// - The scrub and thermal register resets to zero and its reserved bits read zero.
module hbcsr_regs
    import hbcsr_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    input  wire logic        processor_reset_n,
    input  wire logic        address_strap_line_n,
    input  wire logic        scrub_pass_done,
    input  wire logic        write_throttled,
    input  wire logic        read_throttled,
    output logic             scrub_enable,
    output logic      [3:0]  in_order_queue_depth
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    hbcsr_state_s state_reg;
    hbcsr_state_s state_next;

    logic [7:0]  dword_addr;
    logic        hit_subsys;
    logic        hit_capability_list_pointer;
    logic        hit_cfg0;
    logic [7:0]  cfg0_value;
    logic [15:0] scrub_value;

    assign dword_addr = cfg_addr & HBCSR_DWORD_MASK;
    assign hit_subsys = (dword_addr == HBCSR_OFS_SUBSYS);
    assign hit_capability_list_pointer = (dword_addr == HBCSR_OFS_CAPABILITY_LIST_POINTER);
    assign hit_cfg0   = (dword_addr == HBCSR_OFS_CFG0);

    // ------------------------------------------------------------------
    // Read views
    // ------------------------------------------------------------------
    always_comb begin
        cfg0_value = {HBCSR_CFG0_HI_RSV,
                      state_reg.in_order_queue_depth_bit, 2'h0};
        scrub_value = HBCSR_SCRUB_RST;
        scrub_value[HBCSR_SCRB_WFLAG_BIT] = state_reg.write_throttle_flag;
        scrub_value[HBCSR_SCRB_RFLAG_BIT] = state_reg.read_throttle_flag;
        scrub_value[HBCSR_SCRB_CNT_LO +: 2] = state_reg.scrub_count;
        scrub_value[HBCSR_SCRB_MODE_LO +: 2] = state_reg.scrub_mode;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Write-once identity pair
        if (cfg_wr && hit_subsys && !state_reg.subsys_locked) begin
            if (cfg_be[0]) begin
                state_next.board_vendor_field[7:0] = cfg_wdata[7:0];
            end
            if (cfg_be[1]) begin
                state_next.board_vendor_field[15:8] = cfg_wdata[15:8];
            end
            if (cfg_be[2]) begin
                state_next.board_product_field[7:0] = cfg_wdata[23:16];
            end
            if (cfg_be[3]) begin
                state_next.board_product_field[15:8] = cfg_wdata[31:24];
            end
        end
        if (cfg_wr && hit_subsys) begin
            state_next.subsys_locked = 1'b1;
        end

        // Strap capture on processor reset release
        state_next.proc_reset_n_seen = processor_reset_n;
        if (processor_reset_n && !state_reg.proc_reset_n_seen) begin
            state_next.in_order_queue_depth_bit = address_strap_line_n;
            state_next.in_order_queue = address_strap_line_n
                                        ? HBCSR_IOQ_MAX
                                        : HBCSR_IOQ_SINGLE;
        end

        // Scrub mode and thermal flags, software side
        if (cfg_wr && hit_cfg0 && cfg_be[2]) begin
            state_next.scrub_mode =
                cfg_wdata[16 + HBCSR_SCRB_MODE_LO +: 2];
        end
        if (cfg_wr && hit_cfg0 && cfg_be[3]) begin
            if (!cfg_wdata[16 + HBCSR_SCRB_WFLAG_BIT]) begin
                state_next.write_throttle_flag = 1'b0;
            end
            if (!cfg_wdata[16 + HBCSR_SCRB_RFLAG_BIT]) begin
                state_next.read_throttle_flag = 1'b0;
            end
        end

        // Hardware events win over a same-cycle clear
        if (write_throttled) begin
            state_next.write_throttle_flag = 1'b1;
        end
        if (read_throttled) begin
            state_next.read_throttle_flag = 1'b1;
        end
        if (scrub_pass_done) begin
            state_next.scrub_count = state_reg.scrub_count + 2'h1;
        end

        // Registered read data, zero for unmapped dwords
        if (cfg_rd) begin
            if (hit_subsys) begin
                state_next.rdata = {state_reg.board_product_field,
                                    state_reg.board_vendor_field};
            end else if (hit_capability_list_pointer) begin
                state_next.rdata = {24'h000000, HBCSR_CAP_OFFSET};
            end else if (hit_cfg0) begin
                state_next.rdata = {scrub_value, 8'h00, cfg0_value};
            end else begin
                state_next.rdata = 32'h00000000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg.board_vendor_field       <= HBCSR_SUBSYS_RST;
            state_reg.board_product_field      <= HBCSR_SUBSYS_RST;
            state_reg.subsys_locked            <= 1'b0;
            state_reg.in_order_queue_depth_bit <= HBCSR_IN_ORDER_QUEUE_DEPTH_BIT_RST;
            state_reg.proc_reset_n_seen        <= 1'b0;
            state_reg.in_order_queue           <= HBCSR_IOQ_MAX;
            state_reg.scrub_mode               <= HBCSR_SCRUB_OFF;
            state_reg.scrub_count              <= 2'h0;
            state_reg.write_throttle_flag      <= 1'b0;
            state_reg.read_throttle_flag       <= 1'b0;
            state_reg.rdata                    <= 32'h00000000;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign cfg_rdata            = state_reg.rdata;
    assign scrub_enable         = (state_reg.scrub_mode == HBCSR_SCRUB_ON);
    assign in_order_queue_depth = state_reg.in_order_queue;

endmodule // hbcsr_regs

// ===== sim/hbcsr_regs_props.sv
// Concurrent checks on the configuration register slice ports
module hbcsr_regs_props
    import hbcsr_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  cfg_addr,
    input wire logic        cfg_wr,
    input wire logic        cfg_rd,
    input wire logic [3:0]  cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic        processor_reset_n,
    input wire logic        address_strap_line_n,
    input wire logic        scrub_pass_done,
    input wire logic        write_throttled,
    input wire logic        read_throttled,
    input wire logic        scrub_enable,
    input wire logic [3:0]  in_order_queue_depth
);
    // ----------------------------------------------------------------
    // Sequences and assertions
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd50; cfg_rd && cfg_addr[7:2] == 6'h14; endsequence
    sequence s_wr50; cfg_wr && cfg_addr[7:2] == 6'h14 && cfg_be[2]; endsequence
    sequence s_release; !processor_reset_n ##1 processor_reset_n; endsequence
    chk_cap_value: assert property (cfg_rd && cfg_addr[7:2] == 6'h0d
        |=> cfg_rdata[7:0] == 8'h40) else $error("pointer read wrong");
    chk_cfg0_fixed: assert property (s_rd50 |=> cfg_rdata[7:3] == 5'h01
        && cfg_rdata[1:0] == 2'h0) else $error("config fixed bits wrong");
    chk_scrub_resv: assert property (s_rd50 |=> cfg_rdata[31:26] == 6'h0
        && !cfg_rdata[23] && cfg_rdata[20:18] == 3'h0)
        else $error("scrub reserved bits set");
    chk_strap_take: assert property (s_release |=> in_order_queue_depth
        == ($past(address_strap_line_n) ? HBCSR_IOQ_MAX : HBCSR_IOQ_SINGLE))
        else $error("strap capture wrong");
    chk_depth_legal: assert property (in_order_queue_depth == 4'h1
        || in_order_queue_depth == 4'hc) else $error("queue depth illegal");
    chk_scrub_on: assert property (s_wr50 and cfg_wdata[17:16] == 2'h2
        |=> scrub_enable) else $error("scrubber not enabled");
    chk_scrub_off: assert property (s_wr50 and cfg_wdata[17:16] != 2'h2
        |=> !scrub_enable) else $error("scrubber enabled");
    chk_wflag_set: assert property (write_throttled ##1 s_rd50
        |=> cfg_rdata[25]) else $error("write flag not set");
    chk_rflag_set: assert property (read_throttled ##1 s_rd50
        |=> cfg_rdata[24]) else $error("read flag not set");
endmodule // hbcsr_regs_props

bind hbcsr_regs hbcsr_regs_props i_hbcsr_regs_props (.*);

// ===== sim/testbench.sv
// Self-checking bench for the configuration register slice
module testbench import hbcsr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, cfg_wr, cfg_rd, pr_n, strap_n, done, wthr, rthr;
    logic        scrub_enable, wf, rf, iqd;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be, depth;
    logic [31:0] cfg_wdata, cfg_rdata, d, q;
    logic [1:0]  mode, cnt;
    int          n_fail, checked, seed, i, k;
    // ----------------------------------------------------------------
    // Design, clock and tasks
    // ----------------------------------------------------------------
    hbcsr_regs i_hbcsr_regs (.clk(clk), .rst(rst), .cfg_addr(cfg_addr),
        .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .processor_reset_n(pr_n), .address_strap_line_n(strap_n),
        .scrub_pass_done(done), .write_throttled(wthr),
        .read_throttled(rthr), .scrub_enable(scrub_enable),
        .in_order_queue_depth(depth));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] w);
        @(negedge clk);
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = w;
        cfg_wr = 1'b1;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge clk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clk);
        cfg_rd = 1'b0;
        q = cfg_rdata;
    endtask
    function automatic logic [31:0] exp50();
        return {6'h0, wf, rf, 1'b0, cnt, 3'h0, mode, 8'h0,
                HBCSR_CFG0_HI_RSV, iqd, 2'h0};
    endfunction
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        {mode, cnt, wf, rf, iqd} = 7'h01;
    endtask
    task automatic tally_and_finish();
        if (n_fail == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        {rst, cfg_wr, cfg_rd, pr_n, done, wthr, rthr} = 7'h40;
        {cfg_addr, cfg_be, cfg_wdata, n_fail, checked} = '0;
        strap_n = 1'b1;
        seed = 32'h6972;
        for (k = 0; k < 2; k++) begin
            do_reset();
            rd(8'h2c);
            check(q, 32'h0);
            d = $random(seed);
            wr(8'h2e, k ? 4'h0 : 4'h6, d);
            wr(8'h2c, 4'hf, ~d);
            rd(8'h2c);
            check(q, k ? 32'h0 : d & 32'h00ffff00);
        end
        wr(8'h34, 4'hf, $random(seed));
        rd(8'h34);
        check({24'h0, q[7:0]}, {24'h0, HBCSR_CAP_OFFSET});
        rd(8'h50);
        check(q, exp50());
        for (k = 0; k < 2; k++) begin
            @(negedge clk);
            strap_n = k[0];
            pr_n = 1'b1;
            @(negedge clk);
            strap_n = ~k[0];
            iqd = k[0];
            @(negedge clk);
            check({28'h0, depth}, k ? 32'hc : 32'h1);
            rd(8'h50);
            check(q, exp50());
            pr_n = 1'b0;
        end
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            d[17:16] = k[1:0];
            mode = k[1:0];
            wr(8'h52, 4'h4, d);
            check({31'h0, scrub_enable}, {31'h0, k == 2});
            rd(8'h52);
            check(q, exp50());
        end
        for (i = 0; i < 11; i++) begin
            @(negedge clk);
            done = $random(seed);
            cnt = cnt + done;
        end
        @(negedge clk);
        done = 1'b0;
        rd(8'h50);
        check(q, exp50());
        @(negedge clk);
        wthr = 1'b1;
        wf = 1'b1;
        rd(8'h50);
        wthr = 1'b0;
        check(q, exp50());
        rthr = 1'b1;
        rf = 1'b1;
        rd(8'h50);
        rthr = 1'b0;
        wr(8'h50, 4'h8, 32'h03000000);
        rd(8'h50);
        check(q, exp50());
        wr(8'h50, 4'h8, 32'h0);
        {wf, rf} = 2'h0;
        rd(8'h50);
        check(q, exp50());
        rd(8'h80);
        check(q, 32'h0);
        tally_and_finish();
    end
endmodule // testbench
